// >>> src/irq_pkg.sv
// constants for the event flag, mask and interrupt output block
package irq_pkg;

	// register width and register port address width
	localparam int REG_W = 16;
	localparam int ADDR_W = 16;

	// register offsets on the control port
	localparam logic [15:0] ADDR_L2_PIN_STATUS = 16'h0d10;
	localparam logic [15:0] ADDR_L2_DSP_STATUS = 16'h0d11;
	localparam logic [15:0] ADDR_L2_SYS_STATUS = 16'h0d12;
	localparam logic [15:0] ADDR_L2_PIN_MASK = 16'h0d18;
	localparam logic [15:0] ADDR_L2_DSP_MASK = 16'h0d19;
	localparam logic [15:0] ADDR_L2_SYS_MASK = 16'h0d1a;
	localparam logic [15:0] ADDR_L2_CTRL = 16'h0d1f;
	localparam logic [15:0] ADDR_AON_STATUS = 16'h0d51;
	localparam logic [15:0] ADDR_AON_MASK = 16'h0d53;

	// always-on line 1 field positions
	localparam int BIT_CLAMP_FALL = 7;
	localparam int BIT_CLAMP_RISE = 6;
	localparam int BIT_PIN5_FALL = 5;
	localparam int BIT_PIN5_RISE = 4;
	localparam int BIT_JACK_FALL = 3;
	localparam int BIT_JACK_RISE = 2;

	// line 2 pin status: pin events at bits 3..0
	localparam int BIT_PIN_LO = 0;
	localparam int PIN_COUNT = 4;

	// line 2 dsp status field positions
	localparam int BIT_DSP_MEM_READY = 8;
	localparam int BIT_DSP_REQ_B = 1;
	localparam int BIT_DSP_REQ_A = 0;

	// line 2 system status field positions
	localparam int BIT_SPK_WARN = 15;
	localparam int BIT_SPK_OFF = 14;
	localparam int BIT_HP_SENSE = 13;
	localparam int BIT_ACC_SENSE = 12;
	localparam int BIT_SEQ_DONE = 11;
	localparam int BIT_DYN_SIGNAL = 9;
	localparam int BIT_RATE_B_LOCK = 8;
	localparam int BIT_RATE_A_LOCK = 7;
	localparam int BIT_CLK_SLOW = 6;
	localparam int BIT_CLK_FAST = 5;
	localparam int BIT_LOOP_B_LOCK = 3;
	localparam int BIT_LOOP_A_LOCK = 2;

	// line 2 control: global output mask position and reset value
	localparam int BIT_L2_OUT_MASK = 0;
	localparam logic L2_OUT_MASK_RST = 1'b0;

	// always-on edge selection per bit
	localparam logic [15:0] AON_RISE = 16'h0054;
	localparam logic [15:0] AON_FALL = 16'h00a8;
	localparam logic [15:0] AON_IMPL = AON_RISE | AON_FALL;

	// line 2 pin status: both edges on every pin flag
	localparam logic [15:0] PIN_EDGE = 16'h000f;

	// line 2 dsp status edge selection
	localparam logic [15:0] DSP_RISE = 16'h0103;
	localparam logic [15:0] DSP_FALL = 16'h0003;
	localparam logic [15:0] DSP_IMPL = DSP_RISE | DSP_FALL;

	// line 2 system status: both edges, rising only, and event pulse bits
	localparam logic [15:0] SYS_BOTH = 16'hc38c;
	localparam logic [15:0] SYS_RISE_ONLY = 16'h2860;
	localparam logic [15:0] SYS_PULSE = 16'h1000;
	localparam logic [15:0] SYS_RISE = SYS_BOTH | SYS_RISE_ONLY;
	localparam logic [15:0] SYS_IMPL = SYS_RISE | SYS_PULSE;

	// reset values: status clear, every implemented mask bit set
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] AON_MASK_RST = AON_IMPL;
	localparam logic [15:0] PIN_MASK_RST = PIN_EDGE;
	localparam logic [15:0] DSP_MASK_RST = DSP_IMPL;
	localparam logic [15:0] SYS_MASK_RST = SYS_IMPL;
	localparam logic [15:0] RDATA_RST = 16'h0000;

endpackage : irq_pkg

// >>> src/edge_flag_bank.sv
// one register's worth of synchronised edge detectors and sticky flags
module edge_flag_bank
	import irq_pkg::*;
#(
	parameter logic [15:0] RISE_EN = 16'h0000, // bits set on a rising edge
	parameter logic [15:0] FALL_EN = 16'h0000, // bits set on a falling edge
	parameter logic [15:0] PULSE_EN = 16'h0000 // bits set while source is high
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] src_i,
	input wire logic [15:0] clr_i,
	output logic [15:0] flag_o
);

	// per-bit synchroniser, edge memory and sticky flag
	for (genvar b = 0; b < REG_W; b++)
	begin : g_bit
		logic meta_r; // first stage, read only by sync_r
		logic sync_r; // second stage
		logic prev_r; // last synchronised value
		logic flag_r;
		logic hit; // event seen this cycle
		logic flag_nxt;

		// edge or pulse qualification by the bit's mode
		assign hit = (RISE_EN[b] & sync_r & ~prev_r)
			| (FALL_EN[b] & ~sync_r & prev_r)
			| (PULSE_EN[b] & sync_r);
		// set beats a same-cycle write-one clear
		assign flag_nxt = hit | (flag_r & ~clr_i[b]);

		// two-stage sync, then edge memory and flag
		always_ff @(posedge clk_i or posedge rst_i)
		begin
			if (rst_i)
			begin
				meta_r <= 1'b0;
				sync_r <= 1'b0;
				prev_r <= 1'b0;
				flag_r <= 1'b0;
			end
			else
			begin
				meta_r <= src_i[b];
				sync_r <= meta_r;
				prev_r <= sync_r;
				flag_r <= flag_nxt;
			end
		end

		assign flag_o[b] = flag_r;
	end

endmodule : edge_flag_bank

// >>> src/event_flag_status_and_mask.sv
// sticky event flags, per-flag masks and two interrupt outputs
// Function
// - flags latch on event, clear by writing one
// - line 2 pin flags 3..0 on both edges
// - always-on mask per flag, resets to one
// - mask zero passes flag, one blocks output
// - dsp ready rising; dsp requests both edges
// - speaker warning and shutdown flags both edges
// - accessory on event; headphone on rising edge
// - sequencer done, clock errors on rising edge
// - dynamics, rate, loop locks on both edges
// - always-on paired rise and fall flags
// - line 2 mask registers beside status registers
// - line 2 global output mask, resets zero
module event_flag_status_and_mask
	import irq_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// line 2 pin event sources
	input wire logic [3:0] gpio_i,
	// dsp event sources
	input wire logic dsp_mem_ready_i,
	input wire logic dsp_req_a_i,
	input wire logic dsp_req_b_i,
	// system event sources
	input wire logic spk_warn_i,
	input wire logic spk_off_i,
	input wire logic hp_sense_done_i,
	input wire logic acc_sense_event_i,
	input wire logic seq_done_i,
	input wire logic dyn_signal_i,
	input wire logic rate_a_lock_i,
	input wire logic rate_b_lock_i,
	input wire logic clk_slow_i,
	input wire logic clk_fast_i,
	input wire logic loop_a_lock_i,
	input wire logic loop_b_lock_i,
	// always-on event sources
	input wire logic clamp_i,
	input wire logic pin5_i,
	input wire logic jack_i,
	// interrupt outputs, active high
	output logic irq1_o,
	output logic irq2_o
);

	// timing: a source change shows in its flag three edges later (two sync
	// stages, then the edge compare), and on its irq pin one edge after that;
	// a register write lands on the edge that takes it, so a read in the next
	// cycle already sees the new mask or the cleared flag
	// only the event sources cross domains; the register port runs on clk_i
	// address decode
	// full 16-bit compare; a partial decode would alias 0x0d13 onto a register
	wire sel_pin_st = (reg_addr_i == ADDR_L2_PIN_STATUS);
	wire sel_dsp_st = (reg_addr_i == ADDR_L2_DSP_STATUS);
	wire sel_sys_st = (reg_addr_i == ADDR_L2_SYS_STATUS);
	wire sel_pin_mk = (reg_addr_i == ADDR_L2_PIN_MASK);
	wire sel_dsp_mk = (reg_addr_i == ADDR_L2_DSP_MASK);
	wire sel_sys_mk = (reg_addr_i == ADDR_L2_SYS_MASK);
	wire sel_ctrl = (reg_addr_i == ADDR_L2_CTRL);
	wire sel_aon_st = (reg_addr_i == ADDR_AON_STATUS);
	wire sel_aon_mk = (reg_addr_i == ADDR_AON_MASK);

	// a zero written to a status bit leaves it alone, so software can clear
	// one flag without disturbing the others
	// write-one-to-clear vectors, zero unless that status is written
	wire [15:0] clr_pin = (reg_wr_i && sel_pin_st) ? reg_wdata_i : 16'h0000;
	wire [15:0] clr_dsp = (reg_wr_i && sel_dsp_st) ? reg_wdata_i : 16'h0000;
	wire [15:0] clr_sys = (reg_wr_i && sel_sys_st) ? reg_wdata_i : 16'h0000;
	wire [15:0] clr_aon = (reg_wr_i && sel_aon_st) ? reg_wdata_i : 16'h0000;

	// source vectors placed at their flag positions
	logic [15:0] src_pin;
	logic [15:0] src_dsp;
	logic [15:0] src_sys;
	logic [15:0] src_aon;

	// sticky flag vectors
	logic [15:0] st_pin;
	logic [15:0] st_dsp;
	logic [15:0] st_sys;
	logic [15:0] st_aon;

	// mask registers and their next values
	logic [15:0] mk_pin_r;
	logic [15:0] mk_dsp_r;
	logic [15:0] mk_sys_r;
	logic [15:0] mk_aon_r;
	logic [15:0] mk_pin_nxt;
	logic [15:0] mk_dsp_nxt;
	logic [15:0] mk_sys_nxt;
	logic [15:0] mk_aon_nxt;

	// line 2 global output mask
	// one bit in its own word; the other bits of that word read zero
	logic out_mask_r;
	logic out_mask_nxt;

	// rdata_r loads only on a read strobe, so the last read stays visible
	// read data and interrupt output registers
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic irq1_r;
	logic irq2_r;
	logic irq1_nxt;
	logic irq2_nxt;

	// unused positions are tied low so their flags can never set
	// line 2 pin sources: one pin per bit
	always_comb
	begin
		src_pin = 16'h0000;
		src_pin[BIT_PIN_LO +: PIN_COUNT] = gpio_i;
	end

	// dsp sources
	always_comb
	begin
		src_dsp = 16'h0000;
		src_dsp[BIT_DSP_MEM_READY] = dsp_mem_ready_i;
		src_dsp[BIT_DSP_REQ_B] = dsp_req_b_i;
		src_dsp[BIT_DSP_REQ_A] = dsp_req_a_i;
	end

	// system sources
	always_comb
	begin
		src_sys = 16'h0000;
		src_sys[BIT_SPK_WARN] = spk_warn_i;
		src_sys[BIT_SPK_OFF] = spk_off_i;
		src_sys[BIT_HP_SENSE] = hp_sense_done_i;
		src_sys[BIT_ACC_SENSE] = acc_sense_event_i;
		src_sys[BIT_SEQ_DONE] = seq_done_i;
		src_sys[BIT_DYN_SIGNAL] = dyn_signal_i;
		src_sys[BIT_RATE_B_LOCK] = rate_b_lock_i;
		src_sys[BIT_RATE_A_LOCK] = rate_a_lock_i;
		src_sys[BIT_CLK_SLOW] = clk_slow_i;
		src_sys[BIT_CLK_FAST] = clk_fast_i;
		src_sys[BIT_LOOP_B_LOCK] = loop_b_lock_i;
		src_sys[BIT_LOOP_A_LOCK] = loop_a_lock_i;
	end

	// always-on sources: each source feeds a fall and a rise flag
	always_comb
	begin
		src_aon = 16'h0000;
		src_aon[BIT_CLAMP_FALL] = clamp_i;
		src_aon[BIT_CLAMP_RISE] = clamp_i;
		src_aon[BIT_PIN5_FALL] = pin5_i;
		src_aon[BIT_PIN5_RISE] = pin5_i;
		src_aon[BIT_JACK_FALL] = jack_i;
		src_aon[BIT_JACK_RISE] = jack_i;
	end

	// each bank owns the sync stages of its own sources; bits with no edge
	// or pulse mode keep their flag at zero and read back zero
	// line 2 pin flags, both edges
	edge_flag_bank #(
		.RISE_EN(PIN_EDGE),
		.FALL_EN(PIN_EDGE),
		.PULSE_EN(16'h0000)
	) u_pin_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(src_pin),
		.clr_i(clr_pin),
		.flag_o(st_pin)
	);

	// dsp flags: ready on rising, requests on both edges
	edge_flag_bank #(
		.RISE_EN(DSP_RISE),
		.FALL_EN(DSP_FALL),
		.PULSE_EN(16'h0000)
	) u_dsp_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(src_dsp),
		.clr_i(clr_dsp),
		.flag_o(st_dsp)
	);

	// system flags; accessory detect sets on each completion pulse
	edge_flag_bank #(
		.RISE_EN(SYS_RISE),
		.FALL_EN(SYS_BOTH),
		.PULSE_EN(SYS_PULSE)
	) u_sys_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(src_sys),
		.clr_i(clr_sys),
		.flag_o(st_sys)
	);

	// always-on flags: paired opposite-edge detectors
	edge_flag_bank #(
		.RISE_EN(AON_RISE),
		.FALL_EN(AON_FALL),
		.PULSE_EN(16'h0000)
	) u_aon_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(src_aon),
		.clr_i(clr_aon),
		.flag_o(st_aon)
	);

	// unimplemented mask bits are dropped on write, so a read-back compare
	// by software never sees a bit with no flag behind it
	// mask writes keep only bits that have a flag; the rest read zero
	assign mk_pin_nxt = (reg_wr_i && sel_pin_mk) ? (reg_wdata_i & PIN_EDGE) : mk_pin_r;
	assign mk_dsp_nxt = (reg_wr_i && sel_dsp_mk) ? (reg_wdata_i & DSP_IMPL) : mk_dsp_r;
	assign mk_sys_nxt = (reg_wr_i && sel_sys_mk) ? (reg_wdata_i & SYS_IMPL) : mk_sys_r;
	assign mk_aon_nxt = (reg_wr_i && sel_aon_mk) ? (reg_wdata_i & AON_IMPL) : mk_aon_r;
	assign out_mask_nxt = (reg_wr_i && sel_ctrl) ? reg_wdata_i[BIT_L2_OUT_MASK] : out_mask_r;

	// the global output mask starts clear: line 2 is gated only by the
	// per-flag masks until software chooses to silence the whole line
	// mask registers; all per-flag masks start set so nothing fires early
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mk_pin_r <= PIN_MASK_RST;
			mk_dsp_r <= DSP_MASK_RST;
			mk_sys_r <= SYS_MASK_RST;
			mk_aon_r <= AON_MASK_RST;
			out_mask_r <= L2_OUT_MASK_RST;
		end
		else
		begin
			mk_pin_r <= mk_pin_nxt;
			mk_dsp_r <= mk_dsp_nxt;
			mk_sys_r <= mk_sys_nxt;
			mk_aon_r <= mk_aon_nxt;
			out_mask_r <= out_mask_nxt;
		end
	end

	// the flags never look at the masks; unmasking a flag that is already
	// set raises the output on the next edge
	// unmasked flag terms; a masked flag still latches, only its vote is gated
	wire [15:0] live_pin = st_pin & ~mk_pin_r;
	wire [15:0] live_dsp = st_dsp & ~mk_dsp_r;
	wire [15:0] live_sys = st_sys & ~mk_sys_r;
	wire [15:0] live_aon = st_aon & ~mk_aon_r;

	// trade-off: registering the outputs costs one cycle but keeps decode
	// glitches off the interrupt pins
	// outputs follow the unmasked flags; global mask overrides line 2
	assign irq1_nxt = |live_aon;
	assign irq2_nxt = ~out_mask_r & (|{live_pin, live_dsp, live_sys});

	// read mux; unmapped addresses read zero
	// a read and a write on one edge return the value from before the write
	assign rdata_nxt = sel_pin_st ? st_pin :
		sel_dsp_st ? st_dsp :
		sel_sys_st ? st_sys :
		sel_pin_mk ? mk_pin_r :
		sel_dsp_mk ? mk_dsp_r :
		sel_sys_mk ? mk_sys_r :
		sel_ctrl ? {15'h0000, out_mask_r} :
		sel_aon_st ? st_aon :
		sel_aon_mk ? mk_aon_r :
		16'h0000;

	// read data holds until the next read; outputs registered for clean pins
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rdata_r <= RDATA_RST;
			irq1_r <= 1'b0;
			irq2_r <= 1'b0;
		end
		else
		begin
			if (reg_rd_i)
			begin
				rdata_r <= rdata_nxt;
			end
			irq1_r <= irq1_nxt;
			irq2_r <= irq2_nxt;
		end
	end

	// limitation: a source must hold each level for at least one full clock
	// or the sync stages may miss it; two clocks give margin
	assign reg_rdata_o = rdata_r;
	assign irq1_o = irq1_r;
	assign irq2_o = irq2_r;

endmodule : event_flag_status_and_mask

// >>> tb/host_bfm.sv
// host model: single-cycle register writes and reads on the control port
module host_bfm
(
	input wire logic clk_i,
	input wire logic [15:0] reg_rdata_i,
	output logic [15:0] reg_addr_o = 16'h0000,
	output logic reg_wr_o = 1'b0,
	output logic reg_rd_o = 1'b0,
	output logic [15:0] reg_wdata_o = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	// released lines show the inverse, so a stale value never passes
	task automatic rel();
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~reg_addr_o;
		reg_wdata_o = ~reg_wdata_o;
	endtask : rel
	// one write, held across its taking edge
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		rel();
	endtask : wr
	// one read, data registered by the taking edge
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_i);
		d = reg_rdata_i;
		rel();
	endtask : rd
endmodule : host_bfm

// >>> tb/event_flag_asserts.sv
// assertions on the register port and the interrupt outputs
module event_flag_checker
	import irq_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic irq1_o,
	input wire logic irq2_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic aon_mw; // always-on mask written now
	logic l2_mw; // line 2 mask block 0x0d18..0x0d1b written now
	logic aon_seen_r; // always-on mask written since reset
	logic l2_seen_r; // line 2 mask written since reset
	logic [2:0] wr_h_r; // last three write strobes
	assign aon_mw = reg_wr_i && reg_addr_i == ADDR_AON_MASK;
	assign l2_mw = reg_wr_i && reg_addr_i[15:2] == 14'h0346;
	// remember mask writes; a flag or mask only drops through a write
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aon_seen_r <= 1'b0;
			l2_seen_r <= 1'b0;
			wr_h_r <= 3'h0;
		end
		else
		begin
			aon_seen_r <= aon_seen_r | aon_mw;
			l2_seen_r <= l2_seen_r | l2_mw;
			wr_h_r <= {wr_h_r[1:0], reg_wr_i};
		end
	end
	sequence s_l2_off;
		reg_wr_i && reg_addr_i == ADDR_L2_CTRL && reg_wdata_i[0];
	endsequence
	sequence s_aon_off;
		aon_mw && (reg_wdata_i & AON_IMPL) == AON_IMPL;
	endsequence
	property p_aon_quiet;
		!aon_seen_r |-> !irq1_o;
	endproperty
	a_aon_quiet: assert property (p_aon_quiet) else $error("irq1 with reset masks");
	property p_aon_mask_rst;
		reg_rd_i && reg_addr_i == ADDR_AON_MASK && !aon_seen_r |=> reg_rdata_o == 16'h00fc;
	endproperty
	a_aon_mask_rst: assert property (p_aon_mask_rst) else $error("aon mask reset");
	property p_l2_quiet;
		!l2_seen_r |-> !irq2_o;
	endproperty
	a_l2_quiet: assert property (p_l2_quiet) else $error("irq2 with reset masks");
	property p_irq1_fall;
		$fell(irq1_o) |-> |wr_h_r;
	endproperty
	a_irq1_fall: assert property (p_irq1_fall) else $error("irq1 fell without write");
	property p_irq2_fall;
		$fell(irq2_o) |-> |wr_h_r;
	endproperty
	a_irq2_fall: assert property (p_irq2_fall) else $error("irq2 fell without write");
	property p_l2_off;
		s_l2_off |-> ##2 !irq2_o;
	endproperty
	a_l2_off: assert property (p_l2_off) else $error("irq2 not suppressed");
	property p_aon_off;
		s_aon_off |-> ##2 !irq1_o;
	endproperty
	a_aon_off: assert property (p_aon_off) else $error("irq1 not masked");
	property p_unmapped;
		reg_rd_i && reg_addr_i == 16'h0d13 |=> reg_rdata_o == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : event_flag_checker

bind event_flag_status_and_mask event_flag_checker u_event_flag_checker (.clk_i(clk_i),
	.rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .irq1_o(irq1_o), .irq2_o(irq2_o));

// >>> tb/tb.sv
// self-checking bench for the event flag, mask and interrupt block
module tb
	import irq_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i; // 250 MHz
	logic rst_i; // async, high
	logic [15:0] src [4]; // sources laid out as their status bits
	logic [15:0] addr, wdata, rdata;
	logic wr, rd, irq1, irq2;
	int errors;
	int checked;
	event_flag_status_and_mask u_event_flag_status_and_mask (.clk_i(clk_i), .rst_i(rst_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .gpio_i(src[0][3:0]), .dsp_mem_ready_i(src[1][8]),
		.dsp_req_a_i(src[1][0]), .dsp_req_b_i(src[1][1]), .spk_warn_i(src[2][15]),
		.spk_off_i(src[2][14]), .hp_sense_done_i(src[2][13]), .acc_sense_event_i(src[2][12]),
		.seq_done_i(src[2][11]), .dyn_signal_i(src[2][9]), .rate_b_lock_i(src[2][8]),
		.rate_a_lock_i(src[2][7]), .clk_slow_i(src[2][6]), .clk_fast_i(src[2][5]),
		.loop_b_lock_i(src[2][3]), .loop_a_lock_i(src[2][2]), .clamp_i(src[3][6]),
		.pin5_i(src[3][4]), .jack_i(src[3][2]), .irq1_o(irq1), .irq2_o(irq2));
	host_bfm u_host_bfm (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
		.reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
	// free-running clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// verdict, one place for pass and fail
	task automatic close_out();
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] v;
		u_host_bfm.rd(a, v);
		chk($sformatf("reg %h", a), v, e);
	endtask : rdc
	// wait out sync, detect and output register, then look at both lines
	task automatic irqc(input logic [1:0] e);
		repeat (5) @(negedge clk_i);
		chk("irq", {14'h0000, irq2, irq1}, {14'h0000, e});
	endtask : irqc
	// raise, clear while high, drop, clear: r rise flags, c level flags, f after fall
	task automatic ev(input int i, input logic [15:0] a, r, c, f);
		src[i] = r;
		repeat (4) @(negedge clk_i);
		rdc(a, r);
		u_host_bfm.wr(a, 16'hffff);
		rdc(a, c);
		src[i] = 16'h0000;
		repeat (4) @(negedge clk_i);
		rdc(a, f);
		u_host_bfm.wr(a, 16'hffff);
		rdc(a, 16'h0000);
	endtask : ev
	task automatic t_reset_vals();
		rdc(ADDR_AON_MASK, 16'h00fc);
		rdc(ADDR_L2_PIN_MASK, 16'h000f);
		rdc(ADDR_L2_DSP_MASK, 16'h0103);
		rdc(ADDR_L2_SYS_MASK, 16'hfbec);
		rdc(ADDR_L2_CTRL, 16'h0000);
		u_host_bfm.wr(16'h0d13, 16'hffff);
		rdc(16'h0d13, 16'h0000);
	endtask : t_reset_vals
	task automatic t_edges();
		ev(0, ADDR_L2_PIN_STATUS, 16'h000f, 16'h0000, 16'h000f);
		ev(1, ADDR_L2_DSP_STATUS, 16'h0103, 16'h0000, 16'h0003);
		ev(2, ADDR_L2_SYS_STATUS, 16'hfbec, 16'h1000, 16'hd38c);
		ev(3, ADDR_AON_STATUS, 16'h0054, 16'h0000, 16'h00a8);
	endtask : t_edges
	// per-flag masking on the always-on line; flag latches while masked
	task automatic t_irq1();
		u_host_bfm.wr(ADDR_AON_MASK, 16'h0000);
		src[3][2] = 1'b1;
		irqc(2'b01);
		u_host_bfm.wr(ADDR_AON_MASK, 16'h00fc);
		irqc(2'b00);
		rdc(ADDR_AON_STATUS, 16'h0004);
		u_host_bfm.wr(ADDR_AON_MASK, 16'h00f8);
		irqc(2'b01);
		u_host_bfm.wr(ADDR_AON_STATUS, 16'h0004);
		irqc(2'b00);
		src[3][2] = 1'b0;
		irqc(2'b00);
		rdc(ADDR_AON_STATUS, 16'h0008);
		u_host_bfm.wr(ADDR_AON_STATUS, 16'hffff);
	endtask : t_irq1
	// global output mask on line 2 overrides an unmasked flag
	task automatic t_irq2();
		u_host_bfm.wr(ADDR_L2_PIN_MASK, 16'h0000);
		src[0][1] = 1'b1;
		irqc(2'b10);
		u_host_bfm.wr(ADDR_L2_CTRL, 16'h0001);
		irqc(2'b00);
		rdc(ADDR_L2_CTRL, 16'h0001);
		u_host_bfm.wr(ADDR_L2_CTRL, 16'h0000);
		irqc(2'b10);
		u_host_bfm.wr(ADDR_L2_PIN_STATUS, 16'h0002);
		irqc(2'b00);
		src[0][1] = 1'b0;
		irqc(2'b10);
		u_host_bfm.wr(ADDR_L2_PIN_STATUS, 16'hffff);
		irqc(2'b00);
	endtask : t_irq2
	// dsp and system mask words gate line 2 like the pin mask
	task automatic t_masks();
		u_host_bfm.wr(ADDR_L2_DSP_MASK, 16'h0000);
		rdc(ADDR_L2_DSP_MASK, 16'h0000);
		src[1][8] = 1'b1;
		irqc(2'b10);
		u_host_bfm.wr(ADDR_L2_DSP_MASK, 16'hffff);
		rdc(ADDR_L2_DSP_MASK, 16'h0103);
		irqc(2'b00);
		u_host_bfm.wr(ADDR_L2_DSP_STATUS, 16'hffff);
		src[1][8] = 1'b0;
		u_host_bfm.wr(ADDR_L2_SYS_MASK, 16'h0000);
		src[2][12] = 1'b1;
		irqc(2'b10);
		src[2][12] = 1'b0;
		u_host_bfm.wr(ADDR_L2_SYS_MASK, 16'hffff);
		rdc(ADDR_L2_SYS_MASK, 16'hfbec);
		irqc(2'b00);
		rdc(ADDR_L2_SYS_STATUS, 16'h1000);
		u_host_bfm.wr(ADDR_L2_SYS_STATUS, 16'hffff);
		rdc(ADDR_L2_SYS_STATUS, 16'h0000);
	endtask : t_masks
	initial
	begin
		errors = 0;
		checked = 0;
		foreach (src[i])
			src[i] = 16'h0000;
		rst_i = 1'b1;
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset_vals();
		t_edges();
		t_irq1();
		t_irq2();
		t_masks();
		close_out();
	end
	// whole run is a few hundred cycles; 5000 cycles means a hang
	initial
	begin
		#20000;
		errors++;
		close_out();
	end
endmodule : tb
